// File: logic/dcf_fifo.sv
// Flagged FIFO with offset register, cascade chaining and APB status.
// Assumes data, enables and straps are synchronous to clk.
// Overview of operation
// - Write stores word when enabled, not full
// - Read presents next word when enabled, not empty
// - Load low: write goes to offset register
// - Load low: read returns offset register contents
// - Empty flag low when nothing held
// - Full flag low when all locations used
// - Almost-empty low at or below its offset
// - Almost-full low when free at/below offset
// - Control register bit selects async or registered almost flags
// - Shared output: half full or write cascade
// - Retransmit strobe rereads data in stand-alone mode
// - Master reset empties FIFO, resets flags
// - Output enable low drives data, else released
// - Eighteen-bit input and output words
// - Five decoded occupancy states reported
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.

`timescale 1ns/1ps

module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_en_n,
    input  wire logic              rd_en_n,
    input  wire logic              offset_load_n,
    input  wire logic              out_en_n,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic                   rd_data_oe,
    output logic                   empty_flag_n,
    output logic                   full_flag_n,
    output logic                   almost_empty_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   half_full_or_write_cascade_out,
    output logic                   read_cascade_out,
    input  wire logic              write_cascade_in,
    input  wire logic              read_cascade_in,
    input  wire logic              chain_head_or_retransmit,
    input  wire logic              master_reset_n
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);

    if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("DEPTH must be a power of two within the supported range");
    end

    // ******************************
    // Flag decode
    // ******************************
    function automatic dcf_flags_t calc_flags(input logic [CW-1:0] cnt,
                                              input logic [DATA_W-1:0] ae,
                                              input logic [DATA_W-1:0] af);
        dcf_flags_t f;
        f.empty_n        = (cnt != '0);
        f.full_n         = (cnt != DEPTH_C);
        f.almost_empty_n = !(DATA_W'(cnt) <= ae);
        f.almost_full_n  = !(DATA_W'(DEPTH_C - cnt) <= af);
        f.half_full_n    = !(cnt > HALF_C);
        return f;
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return a == CTRL_OFF || a == STAT_OFF || a == CNT_OFF || a == AEOFF_OFF || a == AFOFF_OFF;
    endfunction

    // ******************************
    // State
    // ******************************
    logic [AW-1:0]     wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0]     count_r, count_nxt;
    logic [DATA_W-1:0] ae_off_r, ae_off_nxt, af_off_r, af_off_nxt, q_off_r, q_off_nxt;
    dcf_ofs_sel_t      wsel_r, wsel_nxt, rsel_r, rsel_nxt;
    dcf_src_t          src_r, src_nxt;
    dcf_flags_t        flags_r, flags_nxt;
    logic              ae_sync_r, ae_sync_nxt, af_sync_r, af_sync_nxt;
    logic              wr_tok_r, wr_tok_nxt, rd_tok_r, rd_tok_nxt;
    logic              wxo_n_r, wxo_n_nxt, rxo_n_r, rxo_n_nxt;
    logic              rt_prev_r, rt_prev_nxt;
    dcf_ctrl_t         ctrl_r, ctrl_nxt;
    logic [31:0]       prdata_r, prdata_nxt;
    logic              pslverr_r, pslverr_nxt;
    logic              clr, wr_do, rd_do, ld_wr, ld_rd, rt;
    logic [DATA_W-1:0] ld_rd_word;
    logic [DATA_W-1:0] mem_q;

    dcf_mem #(
        .W     (DATA_W),
        .DEPTH (DEPTH)
    ) u_mem (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (wr_do),
        .wr_addr (wr_ptr_r),
        .wr_data (wr_data_in),
        .rd_en   (rd_do),
        .rd_addr (rd_ptr_r),
        .rd_data (mem_q)
    );

    // ******************************
    // FIFO control
    // ******************************
    always_comb begin
        clr        = !rst_b || !master_reset_n;
        wr_do      = !wr_en_n && offset_load_n && flags_r.full_n && wr_tok_r;
        rd_do      = !rd_en_n && offset_load_n && flags_r.empty_n && rd_tok_r;
        ld_wr      = !wr_en_n && !offset_load_n;
        ld_rd      = !rd_en_n && !offset_load_n;
        rt         = !ctrl_r.cascade && chain_head_or_retransmit && !rt_prev_r;
        ld_rd_word = (rsel_r == OFS_AE) ? ae_off_r : af_off_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        ae_off_nxt = ae_off_r;
        af_off_nxt = af_off_r;
        q_off_nxt  = q_off_r;
        wsel_nxt   = wsel_r;
        rsel_nxt   = rsel_r;
        src_nxt    = src_r;
        wr_tok_nxt = wr_tok_r;
        rd_tok_nxt = rd_tok_r;
        wxo_n_nxt  = 1'b1;
        rxo_n_nxt  = 1'b1;
        rt_prev_nxt = chain_head_or_retransmit;
        if (wr_do) begin
            wr_ptr_nxt = AW'(wr_ptr_r + 1'b1);
        end
        if (rt) begin
            rd_ptr_nxt = '0;
            count_nxt  = CW'(wr_ptr_nxt);
        end else begin
            if (rd_do) begin
                rd_ptr_nxt = AW'(rd_ptr_r + 1'b1);
                src_nxt    = SRC_MEM;
            end
            count_nxt = CW'(count_r + CW'(wr_do) - CW'(rd_do));
        end
        if (ld_wr) begin
            case (wsel_r)
                OFS_AE: begin
                    ae_off_nxt = wr_data_in;
                    wsel_nxt   = OFS_AF;
                end
                OFS_AF: begin
                    af_off_nxt = wr_data_in;
                    wsel_nxt   = OFS_AE;
                end
                default: wsel_nxt = OFS_AE;
            endcase
        end
        if (ld_rd) begin
            q_off_nxt = ld_rd_word;
            src_nxt   = SRC_OFS;
            rsel_nxt  = (rsel_r == OFS_AE) ? OFS_AF : OFS_AE;
        end
        // Token passing along a depth chain
        if (ctrl_r.cascade) begin
            if (wr_do && count_nxt == DEPTH_C) begin
                wr_tok_nxt = 1'b0;
                wxo_n_nxt  = 1'b0;
            end else if (!write_cascade_in) begin
                wr_tok_nxt = 1'b1;
            end
            if (rd_do && count_nxt == '0 && !wr_tok_nxt) begin
                rd_tok_nxt = 1'b0;
                rxo_n_nxt  = 1'b0;
            end else if (!read_cascade_in) begin
                rd_tok_nxt = 1'b1;
            end
        end
        if (clr) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt  = '0;
            ae_off_nxt = AE_OFF_RST;
            af_off_nxt = AF_OFF_RST;
            q_off_nxt  = '0;
            wsel_nxt   = OFS_AE;
            rsel_nxt   = OFS_AE;
            src_nxt    = SRC_MEM;
            wxo_n_nxt  = 1'b1;
            rxo_n_nxt  = 1'b1;
            rt_prev_nxt = 1'b0;
            // Chain head strap caught at reset
            wr_tok_nxt = !ctrl_r.cascade || !chain_head_or_retransmit;
            rd_tok_nxt = !ctrl_r.cascade || !chain_head_or_retransmit;
        end
        flags_nxt   = calc_flags(count_nxt, ae_off_nxt, af_off_nxt);
        ae_sync_nxt = clr ? 1'b0 : flags_r.almost_empty_n;
        af_sync_nxt = clr ? 1'b1 : flags_r.almost_full_n;
    end

    // ******************************
    // APB slave
    // ******************************
    always_comb begin
        ctrl_nxt    = ctrl_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            pslverr_nxt = !reg_hit(paddr);
            case (paddr)
                CTRL_OFF:  prdata_nxt = 32'(ctrl_r);
                STAT_OFF:  prdata_nxt = 32'({rd_tok_r, wr_tok_r, flags_r});
                CNT_OFF:   prdata_nxt = 32'(count_r);
                AEOFF_OFF: prdata_nxt = 32'(ae_off_r);
                AFOFF_OFF: prdata_nxt = 32'(af_off_r);
                default:   prdata_nxt = '0;
            endcase
        end else if (psel && penable) begin
            pslverr_nxt = pslverr_r;
        end
        if (psel && penable && pwrite && paddr == CTRL_OFF) begin
            ctrl_nxt.async_almost = pwdata[CTRL_ASYNC_BIT];
            ctrl_nxt.cascade      = pwdata[CTRL_CASC_BIT];
        end
        if (!rst_b) begin
            ctrl_nxt    = dcf_ctrl_t'(CTRL_RST);
            prdata_nxt  = '0;
            pslverr_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        wr_ptr_r  <= wr_ptr_nxt;
        rd_ptr_r  <= rd_ptr_nxt;
        count_r   <= count_nxt;
        ae_off_r  <= ae_off_nxt;
        af_off_r  <= af_off_nxt;
        q_off_r   <= q_off_nxt;
        wsel_r    <= wsel_nxt;
        rsel_r    <= rsel_nxt;
        src_r     <= src_nxt;
        flags_r   <= flags_nxt;
        ae_sync_r <= ae_sync_nxt;
        af_sync_r <= af_sync_nxt;
        wr_tok_r  <= wr_tok_nxt;
        rd_tok_r  <= rd_tok_nxt;
        wxo_n_r   <= wxo_n_nxt;
        rxo_n_r   <= rxo_n_nxt;
        rt_prev_r <= rt_prev_nxt;
        ctrl_r    <= ctrl_nxt;
        prdata_r  <= prdata_nxt;
        pslverr_r <= pslverr_nxt;
    end

    // ******************************
    // Outputs
    // ******************************
    assign prdata              = prdata_r;
    assign pready              = 1'b1;
    assign pslverr             = psel && penable && pslverr_r;
    assign rd_data_out         = (src_r == SRC_OFS) ? q_off_r : mem_q;
    assign rd_data_oe          = !out_en_n;
    assign empty_flag_n        = flags_r.empty_n;
    assign full_flag_n         = flags_r.full_n;
    assign almost_empty_flag_n = ctrl_r.async_almost ? flags_r.almost_empty_n : ae_sync_r;
    assign almost_full_flag_n  = ctrl_r.async_almost ? flags_r.almost_full_n : af_sync_r;
    assign half_full_or_write_cascade_out = ctrl_r.cascade ? wxo_n_r : flags_r.half_full_n;
    assign read_cascade_out    = rxo_n_r;

    // ******************************
    // Checks
    // ******************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !master_reset_n);

    property p_wr_adv;
        wr_do |=> wr_ptr_r == AW'($past(wr_ptr_r) + 1'b1);
    endproperty
    a_wr_adv: assert property (p_wr_adv) else $error("write did not advance");

    property p_full_block;
        (!full_flag_n && !rt) |=> $stable(wr_ptr_r);
    endproperty
    a_full_block: assert property (p_full_block) else $error("write while full");

    property p_rd_adv;
        (rd_do && !rt) |=> rd_ptr_r == AW'($past(rd_ptr_r) + 1'b1) && src_r == SRC_MEM;
    endproperty
    a_rd_adv: assert property (p_rd_adv) else $error("read did not advance");

    property p_ld_wr;
        ld_wr |=> $stable(wr_ptr_r) && (ae_off_r == $past(wr_data_in) || af_off_r == $past(wr_data_in));
    endproperty
    a_ld_wr: assert property (p_ld_wr) else $error("offset load lost");

    property p_ld_rd;
        ld_rd |=> rd_data_out == $past(ld_rd_word) && rsel_r != $past(rsel_r);
    endproperty
    a_ld_rd: assert property (p_ld_rd) else $error("offset read wrong");

    property p_empty;
        empty_flag_n == (count_r != '0);
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag mismatch");

    property p_full;
        full_flag_n == (count_r != DEPTH_C);
    endproperty
    a_full: assert property (p_full) else $error("full flag mismatch");

    property p_sync_ae;
        (!ctrl_r.async_almost && !$past(clr)) |-> almost_empty_flag_n == $past(flags_r.almost_empty_n);
    endproperty
    a_sync_ae: assert property (p_sync_ae) else $error("sync almost empty lag wrong");

    property p_half;
        (!ctrl_r.cascade && count_r > HALF_C) |-> !half_full_or_write_cascade_out;
    endproperty
    a_half: assert property (p_half) else $error("half full missing");

    property p_mreset;
        @(posedge clk) disable iff (!rst_b) !master_reset_n |=> count_r == '0 && !empty_flag_n;
    endproperty
    a_mreset: assert property (p_mreset) else $error("master reset did not empty");

endmodule

// File: logic/dcf_pkg.sv
// Shared constants, types and register map for the flagged FIFO.
// Assumes one clock for both ports and an APB register slave.

package dcf_pkg;

    // ******************************
    // Sizes
    // ******************************
    localparam int DATA_W    = 18;
    localparam int DEPTH_DEF = 8192;
    localparam int DEPTH_MIN = 8;
    localparam int DEPTH_MAX = 65536;
    localparam int ADDR_W    = 12;

    // ******************************
    // Reset values of flag offsets
    // ******************************
    localparam logic [DATA_W-1:0] AE_OFF_RST = 18'h00007;
    localparam logic [DATA_W-1:0] AF_OFF_RST = 18'h00007;

    // ******************************
    // Register map
    // ******************************
    localparam logic [ADDR_W-1:0] CTRL_OFF  = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFF  = 12'h004;
    localparam logic [ADDR_W-1:0] CNT_OFF   = 12'h008;
    localparam logic [ADDR_W-1:0] AEOFF_OFF = 12'h00c;
    localparam logic [ADDR_W-1:0] AFOFF_OFF = 12'h010;

    localparam int CTRL_ASYNC_BIT = 0;
    localparam int CTRL_CASC_BIT  = 1;
    localparam int STAT_WTOK_BIT  = 5;
    localparam int STAT_RTOK_BIT  = 6;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // ******************************
    // Types
    // ******************************
    typedef struct packed {
        logic half_full_n;
        logic almost_full_n;
        logic almost_empty_n;
        logic full_n;
        logic empty_n;
    } dcf_flags_t;

    localparam dcf_flags_t FLAGS_RST = 5'h1e;

    typedef struct packed {
        logic cascade;
        logic async_almost;
    } dcf_ctrl_t;

    typedef enum logic {OFS_AE, OFS_AF} dcf_ofs_sel_t;
    typedef enum logic {SRC_MEM, SRC_OFS} dcf_src_t;

endpackage

// File: logic/dcf_mem.sv
// Storage array of the FIFO with one write and one registered read port.
// Assumes the caller never reads and writes beyond the array size.

`timescale 1ns/1ps

module dcf_mem #(
    parameter int W     = 18,
    parameter int DEPTH = 8192
) (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [W-1:0]             wr_data,
    input  wire logic                     rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [W-1:0]             rd_data
);

    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] rd_data_nxt;

    // ******************************
    // Array
    // ******************************
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // ******************************
    // Read register
    // ******************************
    always_comb begin
        rd_data_nxt = rd_data;
        if (!rst_b) begin
            rd_data_nxt = '0;
        end else if (rd_en) begin
            rd_data_nxt = mem_r[rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= rd_data_nxt;
    end

endmodule

// File: dv/dcf_agent.sv
// Writing and reading agent standing on the data ports of the FIFO.
// Assumes the bench raises requests by non-blocking assignment after a rising edge.

`timescale 1ns/1ps

module dcf_agent
    import dcf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              wr_req,
    input  wire logic [DATA_W-1:0] wr_word,
    input  wire logic              rd_req,
    output logic      [DATA_W-1:0] wr_data_in,
    output logic                   wr_en_n,
    output logic                   rd_en_n
);
    logic [DATA_W-1:0] last_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            last_r <= 18'h2aaaa;
        end else if (wr_req) begin
            last_r <= wr_word;
        end
    end

    // No request while reset is held
    assign wr_en_n    = !(wr_req && rst_b);
    assign rd_en_n    = !(rd_req && rst_b);
    // Idle bus shows the inverse of the last word
    assign wr_data_in = wr_req ? wr_word : ~last_r;
endmodule

// File: dv/dcf_fifo_tb_top.sv
// Self-checking bench for the flagged FIFO at depth 8.
// Assumes the APB slave answers with pready and the agent drives the data ports.

`timescale 1ns/1ps

module dcf_fifo_tb_top
    import dcf_pkg::*;
;
    localparam int DEPTH = 8;
    localparam int AE    = 2;
    localparam int AF    = 3;

    logic              clk, rst_b, psel, penable, pwrite, pready, pslverr, ev;
    logic              wr_req, rd_req, wr_en_n, rd_en_n, rd_data_oe, offset_load_n, out_en_n;
    logic              empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
    logic              half_full_or_write_cascade_out, read_cascade_out, master_reset_n;
    logic              chain_head_or_retransmit, write_cascade_in, read_cascade_in;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rv;
    logic [DATA_W-1:0] wr_word, wr_data_in, rd_data_out;
    int                fails, n_compared, n_wx, n_rx;
    wire  [4:0]        fl = {half_full_or_write_cascade_out, almost_full_flag_n,
                             almost_empty_flag_n, full_flag_n, empty_flag_n};

    dcf_fifo #(.DEPTH(DEPTH)) u_dcf_fifo (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wr_data_in(wr_data_in), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n),
        .offset_load_n(offset_load_n), .out_en_n(out_en_n), .rd_data_out(rd_data_out),
        .rd_data_oe(rd_data_oe), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .half_full_or_write_cascade_out(half_full_or_write_cascade_out),
        .read_cascade_out(read_cascade_out), .write_cascade_in(write_cascade_in),
        .read_cascade_in(read_cascade_in), .chain_head_or_retransmit(chain_head_or_retransmit),
        .master_reset_n(master_reset_n)
    );

    dcf_agent u_dcf_agent (
        .clk(clk), .rst_b(rst_b), .wr_req(wr_req), .wr_word(wr_word), .rd_req(rd_req),
        .wr_data_in(wr_data_in), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (half_full_or_write_cascade_out === 1'b0) n_wx++;
        if (read_cascade_out === 1'b0) n_rx++;
    end

    // ******************************
    // Shared tasks
    // ******************************
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(pready, 1'b1, "pready");
    endtask

    task automatic wr1(input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr_req <= 1'b1;
        wr_word <= d;
        @(posedge clk);
        wr_req <= 1'b0;
    endtask

    task automatic rd1;
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
    endtask

    task automatic flags(input int c);
        chk(fl, {c <= DEPTH/2, DEPTH-c > AF, c > AE, c != DEPTH, c != 0}, "flags");
    endtask

    task automatic mreset;
        @(posedge clk);
        master_reset_n <= 1'b0;
        @(posedge clk);
        master_reset_n <= 1'b1;
        @(posedge clk);
    endtask

    // ******************************
    // Scenarios
    // ******************************
    task automatic t_basic;
        flags(0);
        chk(rd_data_out, 18'h00000, "out after reset");
        chk(rd_data_oe, 1'b1, "oe on");
        out_en_n <= 1'b1;
        @(posedge clk);
        chk(rd_data_oe, 1'b0, "oe off");
        out_en_n <= 1'b0;
        apb(1'b0, 12'hff0, 32'h0);
        chk(ev, 1'b1, "unmapped error");
        chk(rv, 32'h0, "unmapped data");
        $display("done basic");
    endtask

    task automatic t_load;
        @(posedge clk);
        offset_load_n <= 1'b0;
        wr_req <= 1'b1;
        wr_word <= DATA_W'(AE);
        @(posedge clk);
        wr_word <= DATA_W'(AF);
        @(posedge clk);
        wr_req <= 1'b0;
        rd_req <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            if (k == 2) begin
                rd_req <= 1'b0;
                offset_load_n <= 1'b1;
            end
            if (k > 0) chk(rd_data_out, (k == 2) ? AF : AE, "offset read");
        end
        apb(1'b0, AEOFF_OFF, 32'h0);
        chk(rv, AE, "ae offset");
        apb(1'b0, AFOFF_OFF, 32'h0);
        chk(rv, AF, "af offset");
        apb(1'b1, AEOFF_OFF, 32'h9);
        apb(1'b0, AEOFF_OFF, 32'h0);
        chk(rv, AE, "ro offset");
        $display("done load");
    endtask

    task automatic t_fill(input logic async);
        for (int c = 1; c <= DEPTH; c++) begin
            wr1(18'h00100 + DATA_W'(c));
            @(posedge clk);
            if (c == AE + 1) chk(almost_empty_flag_n, async, "ae timing");
            if (c == DEPTH - AF) chk(almost_full_flag_n, !async, "af timing");
            @(posedge clk);
            flags(c);
        end
        wr1(18'h3ffff);
        apb(1'b0, CNT_OFF, 32'h0);
        chk(rv, DEPTH, "count full");
        flags(DEPTH);
        $display("done fill");
    endtask

    task automatic t_drain;
        for (int i = 0; i < DEPTH; i++) begin
            rd1();
            @(posedge clk);
            chk(rd_data_out, 18'h00101 + DATA_W'(i), "read data");
            @(posedge clk);
            flags(DEPTH - 1 - i);
        end
        rd1();
        @(posedge clk);
        chk(rd_data_out, 18'h00100 + DATA_W'(DEPTH), "empty read");
        $display("done drain");
    endtask

    task automatic t_retx;
        wr1(18'h00055);
        wr1(18'h00056);
        mreset();
        chk(empty_flag_n, 1'b0, "mreset empty");
        apb(1'b0, CNT_OFF, 32'h0);
        chk(rv, 32'h0, "mreset count");
        for (int i = 1; i <= 3; i++) wr1(18'h00200 + DATA_W'(i));
        for (int i = 1; i <= 3; i++) begin
            rd1();
            @(posedge clk);
            chk(rd_data_out, 18'h00200 + DATA_W'(i), "pre retx");
        end
        @(posedge clk);
        chain_head_or_retransmit <= 1'b1;
        @(posedge clk);
        chain_head_or_retransmit <= 1'b0;
        rd1();
        @(posedge clk);
        chk(rd_data_out, 18'h00201, "retransmit");
        mreset();
        $display("done retransmit");
    endtask

    task automatic t_casc;
        int a;
        int b;
        apb(1'b1, CTRL_OFF, 32'h2);
        mreset();
        a = n_wx;
        for (int i = 0; i < DEPTH; i++) wr1(18'h00300 + DATA_W'(i));
        repeat (2) @(posedge clk);
        chk(n_wx - a, 1, "write token pulse");
        b = n_rx;
        for (int i = 0; i < DEPTH; i++) rd1();
        repeat (2) @(posedge clk);
        chk(n_rx - b, 1, "read token pulse");
        // Both tokens passed on, empty with default offsets
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rv, 32'h0000001a, "tokens passed on");
        // Write without token is refused, then token comes back
        wr1(18'h003aa);
        @(posedge clk);
        write_cascade_in <= 1'b0;
        @(posedge clk);
        write_cascade_in <= 1'b1;
        wr1(18'h003ab);
        @(posedge clk);
        read_cascade_in <= 1'b0;
        @(posedge clk);
        read_cascade_in <= 1'b1;
        rd1();
        @(posedge clk);
        chk(rd_data_out, 18'h003ab, "token returned");
        apb(1'b1, CTRL_OFF, 32'h0);
        mreset();
        $display("done cascade");
    endtask

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        wr_req = 1'b0;
        rd_req = 1'b0;
        wr_word = '0;
        offset_load_n = 1'b1;
        out_en_n = 1'b0;
        master_reset_n = 1'b1;
        chain_head_or_retransmit = 1'b0;
        write_cascade_in = 1'b1;
        read_cascade_in = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_basic();
        t_load();
        t_fill(1'b0);
        t_drain();
        apb(1'b1, CTRL_OFF, 32'h1);
        t_fill(1'b1);
        t_drain();
        apb(1'b1, CTRL_OFF, 32'h0);
        t_retx();
        t_casc();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
